// ==== inc/tsp_if.sv ====
// two-wire link between master end and slave end
`timescale 1ns/1ps
`default_nettype none
interface tsp_if;
   logic scl_o;
   logic scl_oe_n;
   logic sda_m_o;
   logic sda_m_oe_n;
   logic sda_s_o;
   logic sda_s_oe_n;
   logic scl;
   logic sda;
   // open drain with pull-up
   assign scl = scl_oe_n ? 1'b1 : scl_o;
   assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);
   modport master (output scl_o, output scl_oe_n, output sda_m_o, output sda_m_oe_n, input scl, input sda);
   modport slave (output sda_s_o, output sda_s_oe_n, input scl, input sda);
endinterface
`default_nettype wire

// ==== inc/tsp_pkg.sv ====
// constants shared by both ends of the two-wire port
// Operation
// - master alone starts transfers, drives clock
// - bytes shift most significant bit first
// - data changes only while clock low
// - slave idles until start condition seen
// - start ignored during power-up sequence
// - stop returns interface to idle standby
// - data pin released after power-up
// - transmitter releases, receiver acknowledges ninth clock
// - slave acknowledges identifier and address bytes
// - master acknowledges read bytes wanting more
// - upper seven bits select one of two spaces
// - identifier low bit one reads, zero writes
// - acknowledge identifier only on a match
// - one address byte, else internal counter
// - address counter resets to zero
// - random read repeats same identifier twice
// - write is id, address, one data, stop
// - addressed read uses repeated start then read id
// - slave sends while master keeps acknowledging
// - pointer increments, wraps after last location
// - user space holds 128 bytes
`default_nettype none
package tsp_pkg;
   localparam int unsigned ID_W       = 7;
   // identifier values are arbitrary
   localparam logic [6:0]  ID_CSR     = 7'h51;
   localparam logic [6:0]  ID_MEM     = 7'h2a;
   localparam int unsigned MEM_DEPTH  = 128;
   localparam int unsigned CSR_DEPTH  = 20;
   localparam logic [7:0]  CSR_LAST   = 8'h13;
   localparam logic [7:0]  MEM_LAST   = 8'h7f;
   localparam logic [7:0]  ADDR_RESET = 8'h00;
   localparam logic [3:0]  BIT_LAST   = 4'h7;
   localparam logic [3:0]  BIT_ACK    = 4'h8;
   localparam logic [7:0]  PWRUP_CYC  = 8'h20;
   localparam logic [3:0]  HALF_DIV   = 4'h3;
   localparam logic [7:0]  BYTE_ZERO  = 8'h00;
endpackage

`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench: master and slave ends joined by one link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tsp_pkg::*;
   logic        clk;
   logic        rst;
   logic        req, req_rd, req_csr;
   logic [7:0]  req_addr, req_wdata, req_count;
   logic        m_busy, rd_stb, nack, s_busy, wr_stb, wr_space, b_busy, b_stb;
   logic [7:0]  rd_data, wr_addr, wr_data, sh;
   logic        scl_p, sda_p;
   logic [7:0]  wq[$];
   logic [7:0]  rq[$];
   logic        aq[$];
   logic [16:0] wrq[$];
   int          bcnt = 0;
   int          bad_stb = 0;
   int          err_total = 0;
   int          total_checks = 0;

   tsp_if u_link();
   tsp_if u_bad_link();

   tsp_master u_tsp_master (.CLK(clk), .SYS_RST(rst), .LINK(u_link), .REQ(req), .REQ_RD(req_rd),
      .REQ_CSR(req_csr), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_COUNT(req_count),
      .BUSY(m_busy), .RD_STB(rd_stb), .RD_DATA(rd_data), .NACK(nack));
   tsp_slave u_tsp_slave (.CLK(clk), .SYS_RST(rst), .LINK(u_link), .BUSY(s_busy), .WR_STB(wr_stb),
      .WR_SPACE(wr_space), .WR_ADDR(wr_addr), .WR_DATA(wr_data));
   tsp_slave u_tsp_slave_b (.CLK(clk), .SYS_RST(rst), .LINK(u_bad_link), .BUSY(b_busy), .WR_STB(b_stb),
      .WR_SPACE(), .WR_ADDR(), .WR_DATA());
   tsp_properties u_tsp_properties (.CLK(clk), .SYS_RST(rst), .scl(u_link.scl), .sda(u_link.sda),
      .sda_m_o(u_link.sda_m_o), .sda_m_oe_n(u_link.sda_m_oe_n), .sda_s_o(u_link.sda_s_o),
      .sda_s_oe_n(u_link.sda_s_oe_n));

   always #2 clk = ~clk;

   // strobes and wire bytes, ack bit kept apart
   always @(posedge clk)
   begin
      scl_p <= u_link.scl;
      sda_p <= u_link.sda;
      if (wr_stb) wrq.push_back({wr_space, wr_addr, wr_data});
      if (rd_stb) rq.push_back(rd_data);
      if (b_stb) bad_stb++;
      if (u_link.scl && scl_p && sda_p && !u_link.sda) bcnt = 0;
      else if (u_link.scl && !scl_p)
      begin
         if (bcnt == 8) wq.push_back(sh);
         if (bcnt == 8) aq.push_back(u_link.sda);
         else sh = {sh[6:0], u_link.sda};
         bcnt = (bcnt == 8) ? 0 : bcnt + 1;
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (m_busy !== lvl)
      begin
         @(negedge clk);
         n++;
         if (n > 20000)
         begin
            err_total++;
            $display("Error at %0t: wait for master timed out", $time);
            tally_and_finish();
         end
      end
   endtask

   task automatic xfer(input logic rd, input logic csr, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] c);
      wait_busy(1'b0);
      req = 1'b1; req_rd = rd; req_csr = csr; req_addr = a; req_wdata = d; req_count = c;
      @(negedge clk);
      req = 1'b0;
      wait_busy(1'b1);
      @(negedge clk);
      // second request while busy must be ignored
      req = 1'b1; req_rd = ~rd; req_addr = ~a;
      @(negedge clk);
      req = 1'b0;
      wait_busy(1'b0);
      for (int k = 0; k < 50 && s_busy !== 1'b0; k++) @(negedge clk);
      chk_bit(s_busy, 1'b0);
   endtask

   task automatic pop_w(input logic [7:0] e, input logic k);
      chk_byte(wq.pop_front(), e);
      chk_bit(aq.pop_front(), k);
   endtask

   task automatic wr(input logic csr, input logic [7:0] a, input logic [7:0] d);
      logic [6:0]  id;
      logic [16:0] r;
      id = csr ? ID_CSR : ID_MEM;
      xfer(1'b0, csr, a, d, 8'h01);
      pop_w({id, 1'b0}, 1'b0);
      pop_w(a, 1'b0);
      pop_w(d, 1'b0);
      chk_bit(wq.size() == 0 && wrq.size() == 1, 1'b1);
      r = wrq.pop_front();
      chk_bit(r[16], csr);
      chk_byte(r[15:8], a);
      chk_byte(r[7:0], d);
   endtask

   task automatic rd(input logic csr, input logic [7:0] a, input int n, input logic [7:0] e [4]);
      logic [6:0] id;
      id = csr ? ID_CSR : ID_MEM;
      xfer(1'b1, csr, a, 8'h00, n[7:0]);
      pop_w({id, 1'b0}, 1'b0);
      pop_w(a, 1'b0);
      pop_w({id, 1'b1}, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         pop_w(e[i], i == n - 1);
         chk_byte(rq.pop_front(), e[i]);
      end
      chk_bit(wq.size() == 0, 1'b1);
      chk_bit(nack, 1'b0);
   endtask

   // one third of a bit on the second link
   task automatic bb(input logic c, input logic d);
      u_bad_link.scl_oe_n = c;
      u_bad_link.sda_m_oe_n = d;
      repeat (4) @(negedge clk);
   endtask

   task automatic bb_byte(input logic [7:0] v, input logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         bb(1'b0, v[i]);
         bb(1'b1, v[i]);
         bb(1'b0, v[i]);
      end
      bb(1'b0, 1'b1);
      bb(1'b1, 1'b1);
      chk_bit(u_bad_link.sda, ack);
      bb(1'b0, 1'b1);
   endtask

   initial
   begin
      clk = 1'b0; rst = 1'b1; req = 1'b0; req_rd = 1'b0; req_csr = 1'b0;
      req_addr = 8'h00; req_wdata = 8'h00; req_count = 8'h00;
      u_bad_link.scl_o = 1'b0; u_bad_link.scl_oe_n = 1'b1;
      u_bad_link.sda_m_o = 1'b0; u_bad_link.sda_m_oe_n = 1'b1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      chk_bit(u_link.sda_s_oe_n, 1'b1);
      repeat (40) @(negedge clk);
      wr(1'b1, 8'h12, 8'ha5);
      wr(1'b1, CSR_LAST, 8'h5a);
      wr(1'b1, 8'h00, 8'h3c);
      wr(1'b0, MEM_LAST, 8'hc3);
      wr(1'b0, 8'h00, 8'h96);
      rd(1'b1, 8'h12, 3, '{8'ha5, 8'h5a, 8'h3c, 8'h00});
      rd(1'b0, MEM_LAST, 2, '{8'hc3, 8'h96, 8'h00, 8'h00});
      rd(1'b1, 8'h00, 1, '{8'h3c, 8'h00, 8'h00, 8'h00});
      // foreign identifier, then a matching one after a new start
      bb(1'b1, 1'b0);
      bb(1'b0, 1'b0);
      bb_byte({7'h33, 1'b0}, 1'b1);
      bb_byte(8'h05, 1'b1);
      bb(1'b1, 1'b1);
      bb(1'b1, 1'b0);
      bb(1'b0, 1'b0);
      bb_byte({ID_MEM, 1'b0}, 1'b0);
      bb_byte(8'h10, 1'b0);
      bb(1'b0, 1'b0);
      bb(1'b1, 1'b0);
      bb(1'b1, 1'b1);
      chk_bit(bad_stb == 0, 1'b1);
      chk_bit(b_busy, 1'b0);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ==== sim/tsp_properties.sv ====
// wire-level checks for the two-wire link
`timescale 1ns/1ps
`default_nettype none
module tsp_properties
   import tsp_pkg::*;
(
   // system
   input wire logic CLK,
   input wire logic SYS_RST,
   // link
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_m_o,
   input wire logic sda_m_oe_n,
   input wire logic sda_s_o,
   input wire logic sda_s_oe_n
);
   localparam int PWR = 32;
   logic       s_drv;
   logic       m_drv;
   logic       start;
   logic       scl_p;
   logic       sda_p;
   logic       frame_q;
   logic [7:0] pw_q;

   assign s_drv = !sda_s_oe_n && !sda_s_o;
   assign m_drv = !sda_m_oe_n && !sda_m_o;
   assign start = scl && scl_p && sda_p && !sda;

   // previous line levels
   always_ff @(posedge CLK)
   begin
      scl_p <= scl;
      sda_p <= sda;
   end

   // inside a start..stop frame
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         frame_q <= 1'b0;
      else if (start)
         frame_q <= 1'b1;
      else if (scl && scl_p && !sda_p && sda)
         frame_q <= 1'b0;
   end

   // cycles since reset release
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         pw_q <= 8'h00;
      else if (pw_q != 8'hff)
         pw_q <= pw_q + 8'h01;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   a_rst_release: assert property ($fell(SYS_RST) |-> sda_s_oe_n)
      else $error("slave drives data right after reset");
   a_pwrup_quiet: assert property (pw_q < PWR |-> !s_drv)
      else $error("slave drives during power-up hold");
   a_idle_quiet: assert property (!frame_q |-> !s_drv)
      else $error("slave drives outside a frame");
   a_slave_change: assert property ($changed(s_drv) |-> !scl)
      else $error("slave data changed while clock high");
   a_no_clash: assert property (scl |-> !(s_drv && m_drv))
      else $error("both ends drive data at once");
   a_drive_clocked: assert property ($rose(s_drv) |-> ##[1:40] $rose(scl))
      else $error("slave drive not followed by a master clock");
   a_drive_span: assert property (s_drv |-> ##[0:170] !s_drv)
      else $error("slave holds data line past a byte");
   a_start_clean: assert property (start |-> !s_drv [*4])
      else $error("slave drives at a start");
endmodule
`default_nettype wire

// ==== src/tsp_master.sv ====
// master end: runs write and read transfers on request
`timescale 1ns/1ps
`default_nettype none
module tsp_master
   import tsp_pkg::*;
(
   // system
   input  wire logic       CLK,
   input  wire logic       SYS_RST,
   // link
   tsp_if.master           LINK,
   // request
   input  wire logic       REQ,
   input  wire logic       REQ_RD,
   input  wire logic       REQ_CSR,
   input  wire logic [7:0] REQ_ADDR,
   input  wire logic [7:0] REQ_WDATA,
   input  wire logic [7:0] REQ_COUNT,
   // answer
   output var  logic       BUSY,
   output var  logic       RD_STB,
   output var  logic [7:0] RD_DATA,
   output var  logic       NACK
);
   typedef enum logic [2:0] {
      M_IDLE  = 3'b000,
      M_START = 3'b001,
      M_BYTE  = 3'b011,
      M_ACK   = 3'b010,
      M_STOP  = 3'b110
   } tsp_mst_t;

   tsp_mst_t   st_q;
   logic [3:0] div_q;
   logic [1:0] ph_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   logic [1:0] seq_q;
   logic [7:0] cnt_q;
   logic       rd_q;
   logic       csr_q;
   logic [7:0] adr_q;
   logic [7:0] wd_q;
   logic [1:0] sda_s;
   logic       tick;

   assign tick = div_q == HALF_DIV;

   function automatic logic [7:0] id_byte(input logic csr, input logic rd);
      id_byte = {csr ? ID_CSR : ID_MEM, rd};
   endfunction

   always_ff @(posedge CLK)
   begin
      sda_s <= {sda_s[0], LINK.sda};
   end

   // clock divider, master alone makes the clock
   always_ff @(posedge CLK)
   begin
      if (SYS_RST || st_q == M_IDLE)
         div_q <= 4'h0;
      else
         div_q <= tick ? 4'h0 : div_q + 4'h1;
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         st_q <= M_IDLE;
         ph_q <= 2'h0;
         bit_q <= 3'h0;
         sh_q <= BYTE_ZERO;
         seq_q <= 2'h0;
         cnt_q <= BYTE_ZERO;
         rd_q <= 1'b0;
         csr_q <= 1'b0;
         adr_q <= BYTE_ZERO;
         wd_q <= BYTE_ZERO;
         BUSY <= 1'b0;
         RD_STB <= 1'b0;
         RD_DATA <= BYTE_ZERO;
         NACK <= 1'b0;
         LINK.scl_o <= 1'b1;
         LINK.scl_oe_n <= 1'b1;
         LINK.sda_m_o <= 1'b1;
         LINK.sda_m_oe_n <= 1'b1;
      end
      else
      begin
         RD_STB <= 1'b0;
         if (st_q == M_IDLE)
         begin
            if (REQ)
            begin
               BUSY <= 1'b1;
               NACK <= 1'b0;
               rd_q <= REQ_RD;
               csr_q <= REQ_CSR;
               adr_q <= REQ_ADDR;
               wd_q <= REQ_WDATA;
               cnt_q <= (REQ_COUNT == BYTE_ZERO) ? 8'h01 : REQ_COUNT;
               seq_q <= 2'h0;
               ph_q <= 2'h0;
               st_q <= M_START;
            end
         end
         else if (tick)
         begin
            ph_q <= ph_q + 2'h1;
            unique case (st_q)
               M_START:
               // release, then pull data low under high clock
               unique case (ph_q)
                  2'h0: begin LINK.sda_m_o <= 1'b1; LINK.sda_m_oe_n <= 1'b1; end
                  2'h1: begin LINK.scl_o <= 1'b1; LINK.scl_oe_n <= 1'b1; end
                  2'h2: begin LINK.sda_m_o <= 1'b0; LINK.sda_m_oe_n <= 1'b0; end
                  2'h3:
                  begin
                     LINK.scl_o <= 1'b0;
                     LINK.scl_oe_n <= 1'b0;
                     sh_q <= id_byte(csr_q, seq_q == 2'h2);
                     bit_q <= 3'h0;
                     st_q <= (seq_q == 2'h2) ? M_BYTE : M_BYTE;
                  end
               endcase
               M_BYTE, M_ACK:
               unique case (ph_q)
                  2'h0:
                  begin
                     if (st_q == M_BYTE && (seq_q != 2'h3))
                     begin
                        LINK.sda_m_o <= sh_q[7];
                        LINK.sda_m_oe_n <= 1'b0;
                     end
                     else if (st_q == M_ACK && seq_q == 2'h3)
                     begin
                        LINK.sda_m_o <= cnt_q == 8'h01;
                        LINK.sda_m_oe_n <= cnt_q == 8'h01;
                     end
                     else
                     begin
                        LINK.sda_m_o <= 1'b1;
                        LINK.sda_m_oe_n <= 1'b1;
                     end
                  end
                  2'h1: begin LINK.scl_o <= 1'b1; LINK.scl_oe_n <= 1'b1; end
                  2'h2:
                  begin
                     if (st_q == M_BYTE)
                        sh_q <= {sh_q[6:0], sda_s[1]};
                     else if (seq_q != 2'h3 && sda_s[1])
                        NACK <= 1'b1;
                  end
                  2'h3:
                  begin
                     LINK.scl_o <= 1'b0;
                     LINK.scl_oe_n <= 1'b0;
                     if (st_q == M_BYTE)
                     begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'(BIT_LAST))
                        begin
                           st_q <= M_ACK;
                           if (seq_q == 2'h3)
                           begin
                              RD_DATA <= sh_q;
                              RD_STB <= 1'b1;
                           end
                        end
                     end
                     else if (NACK)
                        st_q <= M_STOP;
                     else
                     begin
                        st_q <= M_BYTE;
                        bit_q <= 3'h0;
                        unique case (seq_q)
                           2'h0:
                           begin
                              sh_q <= adr_q;
                              seq_q <= 2'h1;
                           end
                           2'h1:
                           begin
                              if (rd_q)
                              begin
                                 seq_q <= 2'h2;
                                 st_q <= M_START;
                              end
                              else
                              begin
                                 sh_q <= wd_q;
                                 seq_q <= 2'h2;
                              end
                           end
                           2'h2:
                           begin
                              if (rd_q)
                                 seq_q <= 2'h3;
                              else
                                 st_q <= M_STOP;
                           end
                           2'h3:
                           begin
                              cnt_q <= cnt_q - 8'h01;
                              if (cnt_q == 8'h01)
                                 st_q <= M_STOP;
                           end
                        endcase
                     end
                  end
               endcase
               M_STOP:
               unique case (ph_q)
                  2'h0: begin LINK.sda_m_o <= 1'b0; LINK.sda_m_oe_n <= 1'b0; end
                  2'h1: begin LINK.scl_o <= 1'b1; LINK.scl_oe_n <= 1'b1; end
                  2'h2: begin LINK.sda_m_o <= 1'b1; LINK.sda_m_oe_n <= 1'b1; end
                  2'h3:
                  begin
                     st_q <= M_IDLE;
                     BUSY <= 1'b0;
                  end
               endcase
               default: st_q <= M_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== src/tsp_slave.sv ====
// slave end: two identifiers, register and user memory spaces
`timescale 1ns/1ps
`default_nettype none
module tsp_slave
   import tsp_pkg::*;
(
   // system
   input  wire logic CLK,
   input  wire logic SYS_RST,
   // link
   tsp_if.slave      LINK,
   // user side
   output var  logic BUSY,
   output var  logic WR_STB,
   output var  logic WR_SPACE,
   output var  logic [7:0] WR_ADDR,
   output var  logic [7:0] WR_DATA
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ID   = 3'b001,
      S_ADR  = 3'b011,
      S_DAT  = 3'b010,
      S_RD   = 3'b110,
      S_SKIP = 3'b111
   } tsp_st_t;

   logic [1:0] scl_s;
   logic [1:0] sda_s;
   logic       scl_p;
   logic       sda_p;
   logic [7:0] pwr_q;
   tsp_st_t    st_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic       rd_q;
   logic       csr_q;
   logic [7:0] ptr_q;
   logic       ack_q;
   logic       lead_q;
   logic [7:0] csr_mem [CSR_DEPTH];
   logic [7:0] usr_mem [MEM_DEPTH];
   logic [7:0] rd_byte;
   logic       rise;
   logic       fall;
   logic       start;
   logic       stop;

   // wrap limit per space
   function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic csr);
      logic [7:0] lim;
      lim = csr ? CSR_LAST : MEM_LAST;
      next_ptr = (p == lim) ? ADDR_RESET : p + 8'h01;
   endfunction

   // synchronisers
   always_ff @(posedge CLK)
   begin
      scl_s <= {scl_s[0], LINK.scl};
      sda_s <= {sda_s[0], LINK.sda};
      scl_p <= scl_s[1];
      sda_p <= sda_s[1];
   end

   assign rise  = scl_s[1] & ~scl_p;
   assign fall  = ~scl_s[1] & scl_p;
   assign start = scl_s[1] & scl_p & sda_p & ~sda_s[1];
   assign stop  = scl_s[1] & scl_p & ~sda_p & sda_s[1];
   assign rd_byte = csr_q ? csr_mem[ptr_q[4:0]] : usr_mem[ptr_q[6:0]];

   // power-up hold-off
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         pwr_q <= BYTE_ZERO;
      else if (pwr_q != PWRUP_CYC)
         pwr_q <= pwr_q + 8'h01;
   end

   // protocol engine
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         st_q   <= S_IDLE;
         bit_q  <= 4'h0;
         sh_q   <= BYTE_ZERO;
         rd_q   <= 1'b0;
         csr_q  <= 1'b0;
         ptr_q  <= ADDR_RESET;
         ack_q  <= 1'b0;
         lead_q <= 1'b0;
         WR_STB <= 1'b0;
      end
      else
      begin
         WR_STB <= 1'b0;
         if (start && pwr_q == PWRUP_CYC)
         begin
            st_q   <= S_ID;
            bit_q  <= 4'h0;
            ack_q  <= 1'b0;
            lead_q <= 1'b1;
         end
         else if (stop)
         begin
            st_q  <= S_IDLE;
            ack_q <= 1'b0;
         end
         else if (st_q != S_IDLE && st_q != S_SKIP)
         begin
            if (rise && bit_q <= BIT_LAST)
               sh_q <= {sh_q[6:0], sda_s[1]};
            if (rise && bit_q == BIT_ACK && st_q == S_RD && sda_s[1])
               st_q <= S_SKIP;
            // clock fall closing a start is not a bit
            if (fall && lead_q)
               lead_q <= 1'b0;
            else if (fall)
            begin
               bit_q <= (bit_q == BIT_ACK) ? 4'h0 : bit_q + 4'h1;
               ack_q <= 1'b0;
               if (bit_q == BIT_LAST)
               begin
                  unique case (st_q)
                     S_ID:
                     begin
                        if (sh_q[7:1] == ID_CSR || sh_q[7:1] == ID_MEM)
                        begin
                           ack_q <= 1'b1;
                           rd_q  <= sh_q[0];
                           csr_q <= sh_q[7:1] == ID_CSR;
                        end
                        else
                           st_q <= S_SKIP;
                     end
                     S_ADR, S_DAT: ack_q <= 1'b1;
                     default: ack_q <= 1'b0;
                  endcase
               end
               if (bit_q == BIT_ACK)
               begin
                  unique case (st_q)
                     S_ID: st_q <= rd_q ? S_RD : S_ADR;
                     S_ADR:
                     begin
                        ptr_q <= sh_q;
                        st_q  <= S_DAT;
                     end
                     S_DAT:
                     begin
                        WR_STB <= 1'b1;
                        ptr_q  <= next_ptr(ptr_q, csr_q);
                        st_q   <= S_SKIP;
                     end
                     S_RD: ptr_q <= next_ptr(ptr_q, csr_q);
                     default: st_q <= S_SKIP;
                  endcase
               end
            end
         end
      end
   end

   // write port and memories
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         WR_SPACE <= 1'b0;
         WR_ADDR  <= BYTE_ZERO;
         WR_DATA  <= BYTE_ZERO;
      end
      else if (fall && bit_q == BIT_ACK && st_q == S_DAT && !stop && !start)
      begin
         WR_SPACE <= csr_q;
         WR_ADDR  <= ptr_q;
         WR_DATA  <= sh_q;
         if (csr_q && ptr_q <= CSR_LAST)
            csr_mem[ptr_q[4:0]] <= sh_q;
         else if (!csr_q)
            usr_mem[ptr_q[6:0]] <= sh_q;
      end
   end

   // data pin driver, released by default
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         LINK.sda_s_o    <= 1'b1;
         LINK.sda_s_oe_n <= 1'b1;
         BUSY            <= 1'b0;
      end
      else
      begin
         BUSY <= st_q != S_IDLE;
         if (st_q == S_IDLE || st_q == S_SKIP || start || stop)
         begin
            LINK.sda_s_o    <= 1'b1;
            LINK.sda_s_oe_n <= 1'b1;
         end
         else if (ack_q)
         begin
            LINK.sda_s_o    <= 1'b0;
            LINK.sda_s_oe_n <= 1'b0;
         end
         else if (st_q == S_RD && bit_q <= BIT_LAST && !scl_s[1])
         begin
            LINK.sda_s_o    <= rd_byte[3'(BIT_LAST - bit_q)];
            LINK.sda_s_oe_n <= 1'b0;
         end
         else if (!scl_s[1])
         begin
            LINK.sda_s_o    <= 1'b1;
            LINK.sda_s_oe_n <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire
